/* File: logic/scc_params.svh */
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
// configuration register offset in special function space
`define SCC_CFG_ONE_ADDR 8'he8
`define SCC_TX_BUF_ADDR 8'h9a
`define SCC_RX_BUF_ADDR 8'h9b
// configuration register fields
`define SCC_RATE_LSB 0
`define SCC_OVF_BIT 2
`define SCC_SSEN_BIT 3
`define SCC_AUTOSS_BIT 4
`define SCC_IRQ_SOURCE_SELECT_BIT 5
`define SCC_CFG_RESET 8'h10
`define SCC_CFG_WMASK 8'h3f
// base divide of the core clock for rate code 00
`define SCC_BASE_DIV 8
`define SCC_FIFO_DEPTH 4
`endif

/* File: logic/scc_pkg.sv */
`default_nettype none
package scc_pkg;
	typedef struct packed {
		logic [1:0] reserved;
		logic irq_source_select;
		logic auto_ss;
		logic ss_input_enable;
		logic rx_overflow_write_enable;
		logic [1:0] sclk_rate_select;
	} scc_cfg_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scc_sfr_t;
	typedef enum logic [1:0] {
		SCC_IDLE = 2'b00,
		SCC_SHIFT = 2'b01,
		SCC_GAP = 2'b11
	} scc_state_t;
endpackage
`default_nettype wire

/* File: logic/scc_fifo.sv */
`default_nettype none
module scc_fifo
	import scc_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg, rp_reg;
	logic [AW:0] cnt_reg;
	logic push, pop;
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rp_reg];
	always_ff @(posedge mclk)
	begin
		if (push)
			mem_reg[wp_reg] <= in_data;
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			if (pop)
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // scc_fifo
`default_nettype wire

/* File: logic/scc_clkdiv.sv */
`default_nettype none
`include "scc_params.svh"
module scc_clkdiv
	import scc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic [1:0] rate,
	output logic half_tick
);
	logic [5:0] cnt_reg;
	logic [5:0] half_len;
	// half period of core/8,16,32,64
	always_comb
	begin
		half_len = 6'((`SCC_BASE_DIV / 2) << rate) - 6'h01;
	end
	assign half_tick = run && (cnt_reg >= half_len);
	always_ff @(posedge mclk)
	begin
		if (rst || !run || half_tick)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 6'h01;
	end
endmodule // scc_clkdiv
`default_nettype wire

/* File: logic/scc_top.sv */
// Summary of operation
// - interrupt on receive full when selector 0, transmit empty when 1
// - master, automatic select clear: select output held low
// - master, automatic select set: select low for one byte, then high
// - continuous master: select stays low across the multibyte transfer
// - slave with select enable: transfer only while select input is low
// - overflow write 0: byte arriving before read is discarded
// - overflow write 1: byte arriving before read replaces unread byte
// - master serial clock is core clock over 8, 16, 32 or 64
// - master-slave bit 1 selects master, 0 selects slave
// - continuous: keep sending while data waits, select until all empty
`default_nettype none
`include "scc_params.svh"
module scc_top
	import scc_pkg::*;
#(
	parameter int FIFO_DEPTH = `SCC_FIFO_DEPTH
)(
	input wire logic mclk,
	input wire logic rst,
	input wire scc_sfr_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic master_slave_select,
	input wire logic continuous_transfer_enable,
	input wire logic cpol,
	output logic tx_ready,
	output logic spi_irq,
	output logic sclk_o,
	output logic sclk_oe,
	input wire logic sclk_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe,
	input wire logic miso_i,
	output logic ss_o,
	output logic ss_oe,
	input wire logic ss_i
);
	//****************
	// configuration
	//****************
	scc_cfg_t cfg_reg;
	logic [7:0] rx_buf_reg;
	logic rx_full_reg;
	logic wr_cfg, wr_tx, rd_rx;
	assign wr_cfg = sfr_req.wr && (sfr_req.addr == `SCC_CFG_ONE_ADDR);
	assign wr_tx = sfr_req.wr && (sfr_req.addr == `SCC_TX_BUF_ADDR);
	assign rd_rx = sfr_req.rd && (sfr_req.addr == `SCC_RX_BUF_ADDR);
	always_ff @(posedge mclk)
	begin
		if (rst)
			cfg_reg <= scc_cfg_t'(`SCC_CFG_RESET);
		else if (wr_cfg)
			cfg_reg <= scc_cfg_t'(sfr_req.wdata & `SCC_CFG_WMASK);
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			sfr_rdata <= 8'h00;
		else if (sfr_req.rd && sfr_req.addr == `SCC_CFG_ONE_ADDR)
			sfr_rdata <= cfg_reg;
		else if (rd_rx)
			sfr_rdata <= rx_buf_reg;
		else if (sfr_req.rd)
			sfr_rdata <= 8'h00;
	end

	//****************
	// transmit fifo
	//****************
	logic fifo_valid, fifo_pop;
	logic [7:0] fifo_data;
	scc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(wr_tx),
		.in_ready(tx_ready),
		.in_data(sfr_req.wdata),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	//****************
	// master engine
	//****************
	scc_state_t state_reg;
	logic [7:0] sh_reg;
	logic [3:0] edge_cnt_reg;
	logic sclk_reg, half_tick, is_master, byte_done, slave_sel, s_load, miso_cap_reg;
	logic [7:0] rx_byte;
	logic rx_strobe;
	assign is_master = master_slave_select;
	scc_clkdiv u_div (
		.mclk(mclk),
		.rst(rst),
		.run(is_master && state_reg == SCC_SHIFT),
		.rate(cfg_reg.sclk_rate_select),
		.half_tick(half_tick)
	);
	assign byte_done = half_tick && edge_cnt_reg == 4'hf;
	assign fifo_pop = is_master ? (state_reg == SCC_IDLE && fifo_valid) : s_load;
	always_ff @(posedge mclk)
	begin
		if (rst || !is_master)
		begin
			state_reg <= SCC_IDLE;
			edge_cnt_reg <= 4'h0;
			sclk_reg <= 1'b0;
			sh_reg <= 8'h00;
			miso_cap_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				SCC_IDLE:
				begin
					if (fifo_valid)
					begin
						sh_reg <= fifo_data;
						edge_cnt_reg <= 4'h0;
						state_reg <= SCC_SHIFT;
					end
				end
				SCC_SHIFT:
				begin
					if (half_tick)
					begin
						sclk_reg <= ~sclk_reg;
						edge_cnt_reg <= edge_cnt_reg + 4'h1;
						// sample on rising edge, shift out on falling edge
						if (!sclk_reg)
							miso_cap_reg <= miso_i;
						else
							sh_reg <= {sh_reg[6:0], miso_cap_reg};
					end
					if (byte_done)
					begin
						if (continuous_transfer_enable && fifo_valid)
							state_reg <= SCC_IDLE;
						else
							state_reg <= SCC_GAP;
					end
				end
				SCC_GAP:
					state_reg <= SCC_IDLE;
				default:
					state_reg <= SCC_IDLE;
			endcase
		end
	end
	logic ss_master;
	always_comb
	begin
		if (!cfg_reg.auto_ss)
			ss_master = 1'b0;
		else
			ss_master = (state_reg == SCC_SHIFT) ? 1'b0 :
				(state_reg == SCC_IDLE && fifo_valid && continuous_transfer_enable) ? 1'b0 : 1'b1;
	end
	assign sclk_o = sclk_reg ^ cpol;
	assign sclk_oe = is_master;
	assign mosi_o = is_master ? sh_reg[7] : 1'b0;
	assign mosi_oe = is_master;
	assign ss_o = ss_master;
	assign ss_oe = is_master;

	//****************
	// slave engine
	//****************
	logic s_sclk_d, s_rise, s_fall;
	logic [7:0] s_sh_reg, s_tx_reg;
	logic [2:0] s_cnt_reg;
	assign slave_sel = !is_master && (!cfg_reg.ss_input_enable || !ss_i);
	assign s_rise = !s_sclk_d && (sclk_i ^ cpol);
	assign s_fall = s_sclk_d && !(sclk_i ^ cpol);
	assign s_load = slave_sel && s_cnt_reg == 3'h0 && fifo_valid && s_rise;
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_sclk_d <= 1'b0;
			s_sh_reg <= 8'h00;
			s_tx_reg <= 8'h00;
			s_cnt_reg <= 3'h0;
		end
		else
		begin
			s_sclk_d <= sclk_i ^ cpol;
			if (!slave_sel)
				s_cnt_reg <= 3'h0;
			else if (s_rise)
			begin
				s_sh_reg <= {s_sh_reg[6:0], mosi_i};
				s_cnt_reg <= s_cnt_reg + 3'h1;
				// first edge of a byte takes the next transmit entry
				if (s_cnt_reg == 3'h0)
					s_tx_reg <= fifo_valid ? fifo_data : 8'h00;
			end
			else if (s_fall)
				s_tx_reg <= {s_tx_reg[6:0], 1'b0};
		end
	end
	// data shifts on the falling edge; between bytes it shows bit 7 of the next transmit entry
	assign miso_o = (s_cnt_reg == 3'h0) ? (fifo_valid && fifo_data[7]) : s_tx_reg[7];
	assign miso_oe = slave_sel;

	//****************
	// receive buffer
	//****************
	assign rx_strobe = is_master ? byte_done :
		(slave_sel && s_rise && s_cnt_reg == 3'h7);
	assign rx_byte = is_master ? {sh_reg[6:0], miso_cap_reg} : {s_sh_reg[6:0], mosi_i};
	always_ff @(posedge mclk)
	begin
		if (rst)
			rx_buf_reg <= 8'h00;
		else if (rx_strobe && (!rx_full_reg || rd_rx || cfg_reg.rx_overflow_write_enable))
			rx_buf_reg <= rx_byte;
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			rx_full_reg <= 1'b0;
		else if (rx_strobe)
			rx_full_reg <= 1'b1;
		else if (rd_rx)
			rx_full_reg <= 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			spi_irq <= 1'b0;
		else
			spi_irq <= cfg_reg.irq_source_select ? !fifo_valid : rx_full_reg;
	end
endmodule // scc_top
`default_nettype wire

/* File: dv/scc_slave_model.sv */
`default_nettype none
// **
// serial slave on the far side
// **
module scc_slave_model (
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] got,
	output int nbytes
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx_sh = 8'h00;
	logic [7:0] tx_sh = 8'h00;
	int nbits = 0;
	initial
	begin
		got = 8'h00;
		nbytes = 0;
	end
	// deselected line shows the inverse
	assign miso = ss_n ? ~tx_sh[7] : tx_sh[7];
	always @(negedge ss_n)
	begin
		tx_sh = tx_byte;
		nbits = 0;
	end
	always @(posedge sclk)
		if (!ss_n)
		begin
			rx_sh = {rx_sh[6:0], mosi};
			nbits++;
			if (nbits == 8)
			begin
				got = rx_sh;
				nbytes++;
				nbits = 0;
			end
		end
	always @(negedge sclk)
		if (!ss_n)
			tx_sh = (nbits == 0) ? tx_byte : {tx_sh[6:0], 1'b0};
endmodule // scc_slave_model
`default_nettype wire

/* File: dv/scc_chk.sv */
`default_nettype none
module scc_chk
	import scc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire scc_sfr_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic master_slave_select,
	input wire logic tx_ready,
	input wire logic spi_irq,
	input wire logic sclk_o,
	input wire logic sclk_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic ss_o,
	input wire logic ss_oe,
	input wire logic ss_i
);
	logic [7:0] cfg_reg;
	logic sclk_q;
	int gap_cnt;
	always_ff @(posedge mclk)
	begin
		if (rst)
			cfg_reg <= 8'h10;
		else if (sfr_req.wr && sfr_req.addr == 8'he8)
			cfg_reg <= sfr_req.wdata & 8'h3f;
	end
	// cycles since the serial clock last moved
	always_ff @(posedge mclk)
	begin
		sclk_q <= sclk_o;
		gap_cnt <= rst ? 1000 : (sclk_o != sclk_q) ? 1 : gap_cnt + 1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_cfg_rd;
		sfr_req.rd && sfr_req.addr == 8'he8;
	endsequence
	sequence s_bad_rd;
		sfr_req.rd && !(sfr_req.addr inside {8'he8, 8'h9a, 8'h9b});
	endsequence
	chk_cfg_read: assert property (s_cfg_rd |=> sfr_rdata == cfg_reg)
		else $error("config readback wrong");
	chk_unmapped_zero: assert property (s_bad_rd |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_manual_ss: assert property (master_slave_select && !cfg_reg[4] |-> !ss_o)
		else $error("manual select not low");
	chk_master_pins: assert property (master_slave_select |-> sclk_oe && mosi_oe && ss_oe && !miso_oe)
		else $error("master pin drive wrong");
	chk_slave_pins: assert property (!master_slave_select |-> !sclk_oe && !mosi_oe && !ss_oe)
		else $error("slave pin drive wrong");
	chk_slave_select: assert property (!master_slave_select && cfg_reg[3] && ss_i |-> !miso_oe)
		else $error("unselected slave drives");
	chk_sclk_rate: assert property (master_slave_select && $past(master_slave_select) && sclk_o != sclk_q |-> gap_cnt >= (4 << cfg_reg[1:0]))
		else $error("serial clock too fast");
	chk_auto_idle: assert property (master_slave_select && cfg_reg[4] && ss_o ##1 ss_o |-> $stable(sclk_o))
		else $error("clock runs while deselected");
	chk_irq_txsrc: assert property (cfg_reg[5] && !tx_ready ##1 !tx_ready |-> !spi_irq)
		else $error("irq with transmit full");
endmodule // scc_chk
bind scc_top scc_chk u_chk (.*);
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import scc_pkg::*;
	logic mclk = 0, rst = 1, master_slave_select = 0, continuous_transfer_enable = 0;
	logic cpol = 0, ss_in = 1, ovf = 0, tx_ready, spi_irq, sclk_o, sclk_oe, mosi_o, mosi_oe;
	logic miso_o, miso_oe, ss_o, ss_oe, p_miso, tb_sclk = 0, tb_mosi = 0;
	logic [7:0] sm;
	scc_sfr_t sfr_req = '0;
	logic [7:0] sfr_rdata, s_tx = 8'h00, s_got, mb, exp_rx;
	int failures = 0, n_checks = 0, rx_full = 0, nbytes, n0;
	wire sclk_i = sclk_oe ? sclk_o : tb_sclk;
	wire mosi_i = mosi_oe ? mosi_o : tb_mosi;
	wire ss_i = ss_oe ? ss_o : ss_in;
	wire miso_i = miso_oe ? miso_o : p_miso;
	scc_top DUT (.*);
	scc_slave_model u_slave (.sclk(sclk_i), .ss_n(ss_i), .mosi(mosi_i), .tx_byte(s_tx),
		.miso(p_miso), .got(s_got), .nbytes(nbytes));
	initial
		forever #4 mclk = ~mclk;
	// **
	// tasks
	// **
	task tally_and_finish;
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(logic [7:0] got, logic [7:0] want);
		n_checks++;
		if (got !== want)
		begin
			failures++;
			$display("CHECK FAILED %0t saw %h want %h", $time, got, want);
		end
	endtask
	task sfr(logic w, logic [7:0] a, logic [7:0] d);
		@(negedge mclk);
		sfr_req = '{w, !w, a, d};
		@(negedge mclk);
		sfr_req = '0;
	endtask
	task await(logic v);
		int i;
		for (i = 0; i < 3000 && ss_i !== v; i++)
			@(negedge mclk);
		if (i == 3000)
		begin
			failures++;
			tally_and_finish;
		end
	endtask
	task xfer;
		mb = 8'($urandom);
		s_tx = 8'($urandom);
		sfr(1, 8'h9a, mb);
		await(0);
		await(1);
		repeat (3) @(negedge mclk);
		exp_rx = (rx_full == 0 || ovf) ? s_tx : exp_rx;
		rx_full = 1;
		check(s_got, mb);
	endtask
	// **
	// main sequence
	// **
	initial
	begin
		void'($urandom(3));
		repeat (12) @(negedge mclk);
		rst = 0;
		sfr(0, 8'he8, 8'h00);
		check(sfr_rdata, 8'h10);
		sfr(1, 8'he8, 8'hff);
		sfr(0, 8'he8, 8'h00);
		check(sfr_rdata, 8'h3f);
		sfr(0, 8'h55, 8'h00);
		check(sfr_rdata, 8'h00);
		master_slave_select = 1;
		for (int r = 0; r < 4; r++)
		begin
			ovf = r[0];
			sfr(1, 8'he8, 8'h10 | {5'h00, ovf, 2'(r)});
			xfer;
			xfer;
			check(spi_irq, 1);
			sfr(0, 8'h9b, 8'h00);
			check(sfr_rdata, exp_rx);
			rx_full = 0;
			repeat (2) @(negedge mclk);
			check(spi_irq, 0);
		end
		sfr(1, 8'he8, 8'h30);
		@(negedge mclk);
		check(spi_irq, 1);
		continuous_transfer_enable = 1;
		sfr(1, 8'he8, 8'h14);
		n0 = nbytes;
		repeat (5) sfr(1, 8'h9a, 8'($urandom));
		check(tx_ready, 0);
		sfr(1, 8'h9a, 8'h5a);
		await(1);
		repeat (3) @(negedge mclk);
		check(8'(nbytes - n0), 8'h05);
		sfr(0, 8'h9b, 8'h00);
		check(sfr_rdata, s_tx);
		sfr(1, 8'he8, 8'h00);
		check(ss_o, 0);
		master_slave_select = 0;
		sfr(1, 8'he8, 8'h08);
		repeat (2) @(negedge mclk);
		check(miso_oe, 0);
		// bench acts as master towards the slave engine
		mb = 8'($urandom);
		s_tx = 8'($urandom);
		sfr(1, 8'h9a, s_tx);
		ss_in = 0;
		for (int b = 7; b >= 0; b--)
		begin
			tb_mosi = mb[b];
			repeat (4) @(negedge mclk);
			sm[b] = miso_i;
			tb_sclk = 1;
			repeat (4) @(negedge mclk);
			tb_sclk = 0;
		end
		repeat (4) @(negedge mclk);
		ss_in = 1;
		check(sm, s_tx);
		sfr(0, 8'h9b, 8'h00);
		check(sfr_rdata, mb);
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
